// File: rtl/vc3_mon_pkg.sv
`default_nettype none
package vc3_mon_pkg;
  // Frame geometry: 9 rows of 85 bytes, path overhead in the first column.
  localparam logic [9:0] FRAME_LAST = 10'h2FC;
  localparam logic [9:0] POS_J1     = 10'h000;
  localparam logic [9:0] POS_B3     = 10'h055;
  localparam logic [9:0] POS_C2     = 10'h0AA;
  localparam logic [9:0] POS_G1     = 10'h0FF;
  // Overhead codes, field positions inside the overhead bytes, and persistence and trace repeat counts.
  localparam logic [7:0] LABEL_AIS    = 8'hFF;
  localparam logic [7:0] LABEL_UNEQ   = 8'h00;
  localparam logic [3:0] REI_MAX      = 4'h8;
  localparam int         REI_LSB      = 4;
  localparam int         RDI_BIT      = 3;
  localparam logic [2:0] PERSIST      = 3'h5;
  localparam logic [1:0] TRACE_REPEAT = 2'h2;
  // Register byte offsets.
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_EXPECT   = 8'h04;
  localparam logic [7:0] ADR_DEGRADE  = 8'h08;
  localparam logic [7:0] ADR_DEFECT   = 8'h0C;
  localparam logic [7:0] ADR_TRACE    = 8'h10;
  localparam logic [7:0] ADR_COUNT    = 8'h14;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADR_IRQ_MASK = 8'h1C;
  // Control field positions.
  localparam int CTRL_MON     = 0;
  localparam int CTRL_TIM_DIS = 1;
  localparam int CTRL_SSF_REP = 2;
  localparam int CTRL_RDI_REP = 3;
  localparam int CTRL_CMP     = 4;
  // Interrupt status bit positions.
  localparam int IRQ_TSF = 0;
  localparam int IRQ_SEC = 1;
  localparam int IRQ_AIS = 2;
  // Reset values.
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [23:0] DEGRADE_RST = 24'h010001;
endpackage
`default_nettype wire

// File: rtl/vc3_path_monitor_sink.sv
// Chosen here: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Function
// RQ1: Accept J1 trace, show it to management.
// RQ2: B3 parity over previous frame flags errors.
// RQ3: REI codes one to eight mean one error.
// RQ4: G1 bit five is remote defect flag.
// RQ5: G1 bits six to eight are ignored.
// RQ6: C2 label drives unequipped and alarm detection.
// RQ7: Defects cleared under server fail or alarm.
// RQ8: Management can disable trace mismatch detection.
// RQ9: Five all-ones C2 frames raise alarm defect.
// RQ10: Five other C2 frames clear alarm defect.
// RQ11: Trail fail and degrade outputs from defects.
// RQ12: Unequipped cause needs zero trace and monitoring.
// RQ13: Trace mismatch cause unless unequipped zero trace.
// RQ14: Degraded cause unless trace mismatch present.
// RQ15: Remote cause gated by mismatch, unequipped, enable.
// RQ16: Server fail cause gated by monitoring, enable.
// RQ17: Per-second defect seconds and block counts.
// RQ18: Monitored signal passes through unchanged.
// RQ19: Causes only while mode selects monitored.
module vc3_path_monitor_sink (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic [7:0]  ci_data_i,
  input  wire logic        ci_clk_i,
  input  wire logic        ci_fs_i,
  input  wire logic        server_signal_fail_in_i,
  input  wire logic        one_second_i,
  input  wire logic        equipment_defect_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic      [7:0]  ci_data_o,
  output logic             ci_clk_o,
  output logic             ci_fs_o,
  output logic             trail_signal_fail_o,
  output logic             trail_signal_degrade_o,
  output logic             unequipped_cause_o,
  output logic             trace_mismatch_cause_o,
  output logic             degraded_cause_o,
  output logic             remote_defect_cause_o,
  output logic             server_fail_cause_o,
  output logic      [7:0]  accepted_trace_o
);
  typedef struct packed {
    logic [7:0]  d1, d2;
    logic        ck1, ck2, ck3, fs1, fs2, ssf1, ssf2;
    logic        sec1, sec2, sec3, eq1, eq2;
    logic [7:0]  dat_o;
    logic        ck_o, fs_o;
    logic [9:0]  pos;
    logic [7:0]  par, par_prev;
    logic        par_valid;
    logic [7:0]  trace_cand, acc_trace;
    logic [1:0]  trace_same;
    logic [2:0]  ais_cnt, uneq_cnt, rdi_cnt;
    logic        ais, uneq, rdi, tim, deg, nb, fb;
    logic [15:0] nb_cnt, fb_cnt, nb_sec, fb_sec, deg_err;
    logic [7:0]  deg_run;
    logic        nds_acc, fds_acc, nds, fds;
    logic [4:0]  ctrl;
    logic [7:0]  exp_trace;
    logic [23:0] degcfg;
    logic [2:0]  irq_stat, irq_mask;
    logic        irq, ack;
    logic [31:0] rdat;
    logic        tsf, tsd, c_uneq, c_tim, c_deg, c_rdi, c_ssf;
  } state_t;

  state_t      s;
  state_t      n;
  logic [1:0]  rst_q;
  logic        rst_n;
  logic        ck_rise;
  logic        sec_tick;
  logic [9:0]  cur;
  logic        j1_stb, b3_stb, c2_stb, g1_stb;
  logic        ssf_ais;
  logic        uneq_zero;
  logic        req;
  logic [3:0]  rei;
  logic [31:0] lane_m;
  logic [31:0] rd_mux;

  // Counts frames that disagree with the held state; five in a row flip it.
  function automatic logic [3:0] persist(input logic [2:0] cnt,
                                         input logic       st,
                                         input logic       cond);
    logic [2:0] c;
    c = (cond != st) ? cnt + 3'h1 : 3'h0;
    if (c == vc3_mon_pkg::PERSIST) begin
      return {3'h0, ~st};
    end
    return {c, st};
  endfunction

  // Reset is released through two flops so every state flop leaves reset
  // on the same edge.
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'h1};
    end
  end
  assign rst_n = rst_q[1];

  // Byte lane mask for writes.
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign lane_m[8*g +: 8] = {8{wb_sel_i[g]}};
  end

  // Strobes derived from synchronised link signals and the byte position.
  assign ck_rise   = s.ck2 & ~s.ck3;
  assign sec_tick  = s.sec2 & ~s.sec3;
  assign cur       = s.fs2 ? vc3_mon_pkg::POS_J1 : s.pos;
  assign j1_stb    = ck_rise && cur == vc3_mon_pkg::POS_J1;
  assign b3_stb    = ck_rise && cur == vc3_mon_pkg::POS_B3;
  assign c2_stb    = ck_rise && cur == vc3_mon_pkg::POS_C2;
  assign g1_stb    = ck_rise && cur == vc3_mon_pkg::POS_G1;
  assign ssf_ais   = s.ssf2 | s.ais;
  assign uneq_zero = s.uneq && s.acc_trace == 8'h00;
  assign req       = wb_cyc_i & wb_stb_i;
  assign rei       = s.d2[vc3_mon_pkg::REI_LSB +: 4]; // RQ5

  // Read data selection; unmapped offsets read as zero.
  always_comb begin
    case (wb_adr_i)
      vc3_mon_pkg::ADR_CTRL:     rd_mux = {27'h0, s.ctrl};
      vc3_mon_pkg::ADR_EXPECT:   rd_mux = {24'h0, s.exp_trace};
      vc3_mon_pkg::ADR_DEGRADE:  rd_mux = {8'h0, s.degcfg};
      vc3_mon_pkg::ADR_DEFECT:   rd_mux = {24'h0, s.nds, s.fds, s.rdi,
                                           s.tim, s.uneq, s.ais, s.tsd,
                                           s.tsf};
      vc3_mon_pkg::ADR_TRACE:    rd_mux = {24'h0, s.acc_trace};
      vc3_mon_pkg::ADR_COUNT:    rd_mux = {s.fb_sec, s.nb_sec};
      vc3_mon_pkg::ADR_IRQ_STAT: rd_mux = {29'h0, s.irq_stat};
      vc3_mon_pkg::ADR_IRQ_MASK: rd_mux = {29'h0, s.irq_mask};
      default:                   rd_mux = 32'h0;
    endcase
  end

  // Next state. The link clock is only sampled here, so a byte is taken
  // three system cycles after its edge; the 125 ns link period leaves the
  // data settled long before that.
  always_comb begin
    n      = s;
    n.d1   = ci_data_i;
    n.d2   = s.d1;
    n.ck1  = ci_clk_i;
    n.ck2  = s.ck1;
    n.ck3  = s.ck2;
    n.fs1  = ci_fs_i;
    n.fs2  = s.fs1;
    n.ssf1 = server_signal_fail_in_i;
    n.ssf2 = s.ssf1;
    n.sec1 = one_second_i;
    n.sec2 = s.sec1;
    n.sec3 = s.sec2;
    n.eq1  = equipment_defect_i;
    n.eq2  = s.eq1;
    n.dat_o = s.d2; // RQ18
    n.ck_o  = s.ck2; // RQ18
    n.fs_o  = s.fs2; // RQ18
    n.nb    = 1'h0;
    n.fb    = 1'h0;
    // Byte position and running parity over the whole frame.
    if (ck_rise) begin
      if (s.fs2) begin
        n.pos       = 10'h001;
        n.par_prev  = s.par; // RQ2
        n.par_valid = 1'h1;
        n.par       = s.d2;
      end else begin
        n.pos = (s.pos == vc3_mon_pkg::FRAME_LAST) ? 10'h000
                                                   : s.pos + 10'h001;
        n.par = s.par ^ s.d2; // RQ2
      end
    end
    // Trace byte is accepted after three identical arrivals.
    if (j1_stb) begin
      if (s.d2 == s.trace_cand) begin
        if (s.trace_same != vc3_mon_pkg::TRACE_REPEAT) begin
          n.trace_same = s.trace_same + 2'h1;
        end
        if (n.trace_same == vc3_mon_pkg::TRACE_REPEAT) begin
          n.acc_trace = s.d2; // RQ1
        end
      end else begin
        n.trace_cand = s.d2;
        n.trace_same = 2'h0;
      end
    end
    if (b3_stb) begin
      n.nb = s.par_valid & (s.d2 != s.par_prev); // RQ2
    end
    if (c2_stb) begin
      {n.ais_cnt, n.ais} = persist(s.ais_cnt, s.ais,
                                   s.d2 == vc3_mon_pkg::LABEL_AIS); // RQ9 RQ10 RQ6
      {n.uneq_cnt, n.uneq} = persist(s.uneq_cnt, s.uneq,
                                     s.d2 == vc3_mon_pkg::LABEL_UNEQ); // RQ6
    end
    if (g1_stb) begin
      n.fb = rei != 4'h0 && rei <= vc3_mon_pkg::REI_MAX; // RQ3
      {n.rdi_cnt, n.rdi} = persist(s.rdi_cnt, s.rdi,
                                   s.d2[vc3_mon_pkg::RDI_BIT]); // RQ4
    end
    // Server failure or path alarm suppresses the unequipped, remote and trace mismatch defects.
    if (ssf_ais) begin
      n.uneq     = 1'h0; // RQ7
      n.uneq_cnt = 3'h0;
      n.rdi      = 1'h0; // RQ7
      n.rdi_cnt  = 3'h0;
    end
    n.tim = s.ctrl[vc3_mon_pkg::CTRL_CMP] & ~s.ctrl[vc3_mon_pkg::CTRL_TIM_DIS]
          & (s.acc_trace != s.exp_trace) & ~ssf_ais; // RQ7 RQ8
    // Per-second accounting; a block flagged on the tick opens the next one.
    if (sec_tick) begin
      n.nb_sec  = s.nb_cnt; // RQ17
      n.fb_sec  = s.fb_cnt; // RQ17
      n.nb_cnt  = 16'(s.nb);
      n.fb_cnt  = 16'(s.fb);
      n.deg_err = 16'(s.nb);
      n.nds     = s.nds_acc | s.tsf | s.eq2; // RQ17
      n.fds     = s.fds_acc | s.rdi; // RQ17
      n.nds_acc = 1'h0;
      n.fds_acc = 1'h0;
      if ((s.deg_err >= s.degcfg[15:0]) != s.deg) begin
        n.deg_run = s.deg_run + 8'h01;
        if (n.deg_run >= s.degcfg[23:16]) begin
          n.deg     = ~s.deg; // RQ7
          n.deg_run = 8'h00;
        end
      end else begin
        n.deg_run = 8'h00;
      end
    end else begin
      n.nb_cnt  = s.nb_cnt + 16'(s.nb); // RQ17
      n.fb_cnt  = s.fb_cnt + 16'(s.fb); // RQ17
      n.deg_err = s.deg_err + 16'(s.nb);
      n.nds_acc = s.nds_acc | s.tsf | s.eq2;
      n.fds_acc = s.fds_acc | s.rdi;
    end
    // Consequent actions and fault causes.
    n.tsf    = ssf_ais | uneq_zero | s.tim; // RQ11
    n.tsd    = s.deg; // RQ11
    n.c_uneq = uneq_zero & s.ctrl[vc3_mon_pkg::CTRL_MON]; // RQ12 RQ19
    n.c_tim  = s.tim & ~uneq_zero & s.ctrl[vc3_mon_pkg::CTRL_MON]; // RQ13
    n.c_deg  = s.deg & ~s.tim & s.ctrl[vc3_mon_pkg::CTRL_MON]; // RQ14
    n.c_rdi  = s.rdi & ~uneq_zero & ~s.tim & s.ctrl[vc3_mon_pkg::CTRL_MON]
             & s.ctrl[vc3_mon_pkg::CTRL_RDI_REP]; // RQ15
    n.c_ssf  = ssf_ais & s.ctrl[vc3_mon_pkg::CTRL_MON]
             & s.ctrl[vc3_mon_pkg::CTRL_SSF_REP]; // RQ16
    // Bus: ack one cycle after the request; writes land on the ack edge.
    n.ack = req & ~s.ack;
    if (req && !s.ack) begin
      n.rdat = rd_mux;
    end
    if (req && s.ack && wb_we_i) begin
      case (wb_adr_i)
        vc3_mon_pkg::ADR_CTRL:
          n.ctrl = 5'(({27'h0, s.ctrl} & ~lane_m) | (wb_dat_i & lane_m));
        vc3_mon_pkg::ADR_EXPECT:
          n.exp_trace = 8'(({24'h0, s.exp_trace} & ~lane_m)
                           | (wb_dat_i & lane_m));
        vc3_mon_pkg::ADR_DEGRADE:
          n.degcfg = 24'(({8'h0, s.degcfg} & ~lane_m) | (wb_dat_i & lane_m));
        vc3_mon_pkg::ADR_IRQ_MASK:
          n.irq_mask = 3'(({29'h0, s.irq_mask} & ~lane_m)
                          | (wb_dat_i & lane_m));
        default: ;
      endcase
    end
    // Only bits that were actually returned are cleared, so an event that
    // lands between data capture and ack stays pending; set beats clear.
    n.irq_stat = s.irq_stat;
    if (req && s.ack && !wb_we_i
        && wb_adr_i == vc3_mon_pkg::ADR_IRQ_STAT) begin
      n.irq_stat = s.irq_stat & ~s.rdat[2:0];
    end
    n.irq_stat[vc3_mon_pkg::IRQ_TSF] = n.irq_stat[vc3_mon_pkg::IRQ_TSF]
                                      | (n.tsf & ~s.tsf);
    n.irq_stat[vc3_mon_pkg::IRQ_SEC] = n.irq_stat[vc3_mon_pkg::IRQ_SEC]
                                      | sec_tick;
    n.irq_stat[vc3_mon_pkg::IRQ_AIS] = n.irq_stat[vc3_mon_pkg::IRQ_AIS]
                                      | (n.ais & ~s.ais);
    n.irq = |(n.irq_stat & n.irq_mask);
  end

  // The single state register; clock enable low freezes everything.
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      s        <= '0;
      s.ctrl   <= vc3_mon_pkg::CTRL_RST;
      s.degcfg <= vc3_mon_pkg::DEGRADE_RST;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign wb_dat_o               = s.rdat;
  assign wb_ack_o               = s.ack;
  assign irq_o                  = s.irq;
  assign ci_data_o              = s.dat_o;
  assign ci_clk_o               = s.ck_o;
  assign ci_fs_o                = s.fs_o;
  assign trail_signal_fail_o    = s.tsf;
  assign trail_signal_degrade_o = s.tsd;
  assign unequipped_cause_o     = s.c_uneq;
  assign trace_mismatch_cause_o = s.c_tim;
  assign degraded_cause_o       = s.c_deg;
  assign remote_defect_cause_o  = s.c_rdi;
  assign server_fail_cause_o    = s.c_ssf;
  assign accepted_trace_o       = s.acc_trace;

  // Checks; they assume the clock enable stays high across each window.
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n || !ce_i);

  sequence q_b3_bad;
    b3_stb && s.par_valid && s.d2 != s.par_prev;
  endsequence
  sequence q_rei_hit;
    g1_stb && rei != 4'h0 && rei <= vc3_mon_pkg::REI_MAX;
  endsequence

  property p_pass_through;
    ##3 ci_data_o == $past(ci_data_i, 3) && ci_fs_o == $past(ci_fs_i, 3);
  endproperty
  a_pass_through: assert property (p_pass_through) // RQ18
    else $error("Monitored data altered in passing.");
  property p_b3_error;
    q_b3_bad |=> s.nb ##1 !s.nb;
  endproperty
  a_b3_error: assert property (p_b3_error) // RQ2
    else $error("Parity mismatch not flagged as one block.");
  property p_rei_count;
    q_rei_hit |=> s.fb;
  endproperty
  a_rei_count: assert property (p_rei_count) // RQ3
    else $error("Remote error code not counted.");
  property p_ais_raise;
    $rose(s.ais) |-> $past(s.ais_cnt) == 3'h4 && $past(s.d2) == 8'hFF;
  endproperty
  a_ais_raise: assert property (p_ais_raise) // RQ9
    else $error("Alarm defect raised without five all-ones labels.");
  property p_ais_clear;
    $fell(s.ais) |-> $past(c2_stb) && $past(s.d2) != 8'hFF;
  endproperty
  a_ais_clear: assert property (p_ais_clear) // RQ10
    else $error("Alarm defect cleared without a non-all-ones label.");
  property p_tsf_from_ais;
    s.ais |=> trail_signal_fail_o;
  endproperty
  a_tsf_from_ais: assert property (p_tsf_from_ais) // RQ11
    else $error("Alarm defect did not raise trail signal fail.");
  property p_tim_disable;
    s.ctrl[vc3_mon_pkg::CTRL_TIM_DIS] |=> !s.tim ##1 !trace_mismatch_cause_o;
  endproperty
  a_tim_disable: assert property (p_tim_disable) // RQ8
    else $error("Trace mismatch seen while detection disabled.");
  property p_not_monitored;
    !s.ctrl[vc3_mon_pkg::CTRL_MON] |=> !(unequipped_cause_o
      || trace_mismatch_cause_o || degraded_cause_o
      || remote_defect_cause_o || server_fail_cause_o);
  endproperty
  a_not_monitored: assert property (p_not_monitored) // RQ19
    else $error("Fault cause raised while not monitored.");
  property p_uneq_cause;
    unequipped_cause_o |-> $past(uneq_zero);
  endproperty
  a_uneq_cause: assert property (p_uneq_cause) // RQ12
    else $error("Unequipped cause without zero accepted trace.");
  property p_irq_level;
    |(s.irq_stat & s.irq_mask) |-> irq_o;
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("Interrupt low with an unmasked status bit.");
endmodule
`default_nettype wire

// File: testbench/vc3_link_source.sv
`timescale 1ns/1ps
`default_nettype none
// Upstream path source: whole frames on a link clock that idles low.
module vc3_link_source (
  output logic       ci_clk_o,
  output logic [7:0] ci_data_o,
  output logic       ci_fs_o
);
  logic [7:0] bip;

  // Idle lines before the first frame.
  initial begin
    ci_clk_o  = 1'b0;
    ci_data_o = 8'h00;
    ci_fs_o   = 1'b0;
    bip       = 8'h00;
  end

  // One frame of 765 bytes, overhead J1, B3, C2 and G1 in the first column of the first four rows.
  // Data changes on the falling link edge, so it is stable at the rise;
  // the odd start offset keeps link edges away from system clock edges.
  task automatic send_frame(input logic [7:0] j1, input logic [7:0] c2,
                            input logic [7:0] g1, input logic b3_bad);
    logic [7:0] acc;
    logic [7:0] b;
    acc = 8'h00;
    b   = 8'h00;
    #1.3;
    for (int i = 0; i <= 764; i++) begin
      case (10'(i))
        vc3_mon_pkg::POS_J1: b = j1;
        vc3_mon_pkg::POS_B3: b = bip ^ {7'h00, b3_bad};
        vc3_mon_pkg::POS_C2: b = c2;
        vc3_mon_pkg::POS_G1: b = g1;
        default: b = i[7:0];
      endcase
      acc       = acc ^ b;
      ci_data_o = b;
      ci_fs_o   = (i == 0);
      #62.5 ci_clk_o = 1'b1;
      #62.5 ci_clk_o = 1'b0;
    end
    bip = acc;
    // Released lines show the inverse of the last value, never a hold.
    ci_data_o = ~b;
    ci_fs_o   = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: testbench/test_vc3_path_monitor_sink.sv
`timescale 1ns/1ps
`default_nettype none
module test_vc3_path_monitor_sink;
  // Eight frames take about 95,700 cycles; the ceiling leaves a small margin.
  localparam int CEIL = 99000;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        ssf, sec, eqd, cyc, stb, we, armed;
  logic [7:0]  adr, ldat, odat, trace;
  logic [31:0] wdat, rdat;
  logic        ack, irq, lclk, lfs, oclk, ofs;
  logic        tsf, tsd, uneq_c, tim_c, deg_c, rdi_c, ssf_c;
  logic [9:0]  hist [3];
  int          miscompares;
  int          checks;
  int          cycles;

  vc3_link_source src (.ci_clk_o(lclk), .ci_data_o(ldat), .ci_fs_o(lfs));

  vc3_path_monitor_sink DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .ci_data_i(ldat), .ci_clk_i(lclk), .ci_fs_i(lfs),
    .server_signal_fail_in_i(ssf), .one_second_i(sec),
    .equipment_defect_i(eqd), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .irq_o(irq),
    .ci_data_o(odat), .ci_clk_o(oclk), .ci_fs_o(ofs),
    .trail_signal_fail_o(tsf), .trail_signal_degrade_o(tsd),
    .unequipped_cause_o(uneq_c), .trace_mismatch_cause_o(tim_c),
    .degraded_cause_o(deg_c), .remote_defect_cause_o(rdi_c),
    .server_fail_cause_o(ssf_c), .accepted_trace_o(trace));

  // System clock, 8 ns period.
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic results();
    if (miscompares == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One classic cycle, held until ack is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_sys_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_sys_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // The monitored signal must leave exactly as it came, three cycles on.
  always @(posedge clk_sys_i) begin
    hist[0] <= {lclk, lfs, ldat};
    hist[1] <= hist[0];
    hist[2] <= hist[1];
    if (armed) chk({22'h0, oclk, ofs, odat}, {22'h0, hist[2]});
  end

  // Watchdog: a hang counts as a mismatch and ends the run.
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      miscompares++;
      results();
    end
  end

  // Main sequence; the eight frames dominate the run time.
  initial begin
    rst_n_i     = 1'b0;
    ssf         = 1'b0;
    sec         = 1'b0;
    eqd         = 1'b1;
    cyc         = 1'b0;
    stb         = 1'b0;
    we          = 1'b0;
    adr         = 8'h00;
    wdat        = 32'h0000_0000;
    armed       = 1'b0;
    miscompares = 0;
    checks      = 0;
    cycles      = 0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    waitc(4);
    armed <= 1'b1;
    rd(vc3_mon_pkg::ADR_CTRL, 32'h0000_0000);
    rd(vc3_mon_pkg::ADR_DEGRADE, {8'h00, vc3_mon_pkg::DEGRADE_RST});
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    wr(vc3_mon_pkg::ADR_IRQ_MASK, 32'h0000_0007);
    wr(vc3_mon_pkg::ADR_EXPECT, 32'h0000_005A);
    // Compare stays off until the trace has been accepted.
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_000D);
    // REI 0, then REI 8 with a B3 error and junk in the low bits, then REI 9.
    src.send_frame(8'h5A, 8'h01, 8'h00, 1'b0);
    src.send_frame(8'h5A, 8'h01, 8'h87, 1'b1);
    src.send_frame(8'h5A, 8'h01, 8'h90, 1'b0);
    waitc(20);
    sec <= 1'b1;
    waitc(4);
    sec <= 1'b0;
    waitc(20);
    rd(vc3_mon_pkg::ADR_COUNT, 32'h0001_0001);
    rd(vc3_mon_pkg::ADR_DEFECT, 32'h0000_0082);
    rd(vc3_mon_pkg::ADR_TRACE, 32'h0000_005A);
    chk({24'h0, trace}, 32'h0000_005A);
    chk1(tsd, 1'b1);
    chk1(deg_c, 1'b1);
    chk1(rdi_c, 1'b0);
    chk1(uneq_c, 1'b0);
    chk1(irq, 1'b1);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0002);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0000);
    waitc(3);
    chk1(irq, 1'b0);
    // Wrong expected trace raises mismatch; the disable hides it again.
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_001D);
    wr(vc3_mon_pkg::ADR_EXPECT, 32'h0000_0033);
    waitc(10);
    chk1(tim_c, 1'b1);
    chk1(tsf, 1'b1);
    chk1(deg_c, 1'b0);
    rd(vc3_mon_pkg::ADR_DEFECT, 32'h0000_0093);
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_001F);
    waitc(10);
    chk1(tim_c, 1'b0);
    chk1(tsf, 1'b0);
    chk1(deg_c, 1'b1);
    wr(vc3_mon_pkg::ADR_EXPECT, 32'h0000_005A);
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_001D);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0001);
    // Server fail with reporting on, then off, then monitoring off.
    ssf <= 1'b1;
    waitc(10);
    chk1(tsf, 1'b1);
    chk1(ssf_c, 1'b1);
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_0019);
    waitc(5);
    chk1(ssf_c, 1'b0);
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_0018);
    waitc(5);
    chk1(deg_c, 1'b0);
    chk1(tsf, 1'b1);
    ssf <= 1'b0;
    wr(vc3_mon_pkg::ADR_CTRL, 32'h0000_001D);
    waitc(10);
    chk1(tsf, 1'b0);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0001);
    // Four all-ones labels are not enough; the fifth raises the alarm.
    repeat (4) src.send_frame(8'h5A, 8'hFF, 8'h00, 1'b0);
    waitc(20);
    chk1(tsf, 1'b0);
    src.send_frame(8'h5A, 8'hFF, 8'h00, 1'b0);
    waitc(20);
    chk1(tsf, 1'b1);
    chk1(ssf_c, 1'b1);
    rd(vc3_mon_pkg::ADR_DEFECT, 32'h0000_0087);
    chk1(irq, 1'b1);
    wr(vc3_mon_pkg::ADR_IRQ_MASK, 32'h0000_0000);
    waitc(3);
    chk1(irq, 1'b0);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0005);
    rd(vc3_mon_pkg::ADR_IRQ_STAT, 32'h0000_0000);
    results();
  end
endmodule
`default_nettype wire
